// ### rtl/bpt_pkg.sv
// Constants and types shared by the pattern fill and text draw engine.
// Overview of operation
// - Pattern fill tiles the 8x8 pattern over the whole destination rectangle.
// - Vertical alignment zero maps top pattern row to top scan line, one per line.
// - Raster code F0h writes the pattern value unchanged.
// - Text with source select takes its glyph dwords whatever the raster code.
// - Raster code CCh writes the source value unchanged.
// - A raster code without a pattern term issues no pattern reads.
// - Destination line start advances by the signed byte pitch per scan line.
// - Pattern base uses address bits 31 to 3 only, quadword aligned.
// - Destination address is the byte address of the first written byte.
// - Pattern fill height counts scan lines, width counts bytes per line.
// - Text source bytes follow the text command in the command stream.
// - Monochrome source is colour-expanded with foreground and background first.
// - Transparent text leaves pixels whose source bit is background unwritten.
// - Clipped text writes only pixels inside the clip window, edges included.
// - Glyph lines come from one continuous bit stream, no padding or address.
// - Text extent comes from start and end X and Y, not width and height.
// - At 8 bits per pixel the colour is bits 7 to 0, one index per pixel.
// - Fields unused by the current command are ignored.
// - Dynamic colour enabled with depth zero means an 8 bpp pattern.
// - Transparency mode zero writes every unclipped pixel of the rectangle.
// - Source bit one expands to foreground, zero to background.
package bpt_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0] OFS_STATUS = 6'h00;
  localparam logic [5:0] OFS_SETUP = 6'h04;
  localparam logic [5:0] OFS_PITCH = 6'h08;
  localparam logic [5:0] OFS_PAT_BASE = 6'h0C;
  localparam logic [5:0] OFS_DST_BASE = 6'h10;
  localparam logic [5:0] OFS_FG = 6'h14;
  localparam logic [5:0] OFS_BG = 6'h18;
  localparam logic [5:0] OFS_CLIP_MIN = 6'h1C;
  localparam logic [5:0] OFS_CLIP_MAX = 6'h20;
  localparam logic [5:0] OFS_DONE_CNT = 6'h24;

  // Setup register fields.
  localparam int SETUP_ROP_LSB = 0;
  localparam int SETUP_VALIGN_LSB = 8;
  localparam int SETUP_DYN_EN_BIT = 11;
  localparam int SETUP_DYN_DEPTH_LSB = 12;
  localparam logic [31:0] SETUP_RESET = 32'h0000_00F0;

  // Command dword 0 fields.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SRC_SEL_BIT = 2;
  localparam int CMD_CLIP_EN_BIT = 3;
  localparam int CMD_TRANS_BIT = 4;

  // Command opcodes.
  localparam logic [1:0] OP_PATTERN_FILL = 2'h1;
  localparam logic [1:0] OP_TEXT_IMM = 2'h2;

  // Raster codes named for reference by software.
  localparam logic [7:0] ROP_PAT_COPY = 8'hF0;
  localparam logic [7:0] ROP_SRC_COPY = 8'hCC;

  // Pattern geometry: 8x8 pixels, 8 bytes per row at 8 bpp.
  localparam int PAT_DIM_BITS = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARG1 = 3'b001,
    ST_ARG2 = 3'b010,
    ST_PIX = 3'b011,
    ST_SRC = 3'b100,
    ST_PRD = 3'b101,
    ST_DRD = 3'b110,
    ST_WR = 3'b111
  } bpt_state_e;

endpackage

// ### rtl/bpt_engine.sv
// Pattern fill and immediate text draw engine with Avalon-MM registers.
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bpt_engine (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Avalon-MM register slave.
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Command stream from the command streamer.
  input wire logic i_cmd_valid,
  input wire logic [31:0] i_cmd_data,
  output logic o_cmd_ready,
  // Frame-buffer byte port.
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [31:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_mem_wait,
  output logic o_busy
);

  bpt_pkg::bpt_state_e state_reg;

  // Software state.
  logic [31:0] setup_reg;
  logic [15:0] pitch_reg;
  logic [31:0] pat_base_reg;
  logic [31:0] dst_base_reg;
  logic [31:0] fg_reg;
  logic [31:0] bg_reg;
  logic [31:0] clip_min_reg;
  logic [31:0] clip_max_reg;
  logic [15:0] done_cnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // Command state.
  logic [1:0] op_reg;
  logic src_sel_reg;
  logic clip_en_reg;
  logic trans_reg;
  logic [31:0] arg1_reg;
  logic [31:0] line_addr_reg;
  logic [15:0] x_reg;
  logic [15:0] y_reg;
  logic [15:0] x_start_reg;
  logic [15:0] x_end_reg;
  logic [15:0] y_start_reg;
  logic [15:0] y_end_reg;
  logic [31:0] bits_reg;
  logic [5:0] bit_cnt_reg;
  logic cur_bit_reg;
  logic [7:0] pat_byte_reg;
  logic [7:0] dst_byte_reg;

  // Raster code decode.
  logic [7:0] rop;
  logic uses_pat;
  logic uses_src;
  logic uses_dst;
  logic is_text;
  logic pix_bit;
  logic in_clip;
  logic write_ok;
  logic last_x;
  logic last_y;
  logic [7:0] src_byte;
  logic [7:0] result;
  logic [2:0] pat_row;
  logic [2:0] pat_col;
  logic [31:0] pat_addr;
  logic [31:0] pix_addr;
  logic [32:0] y1_offset;
  logic [31:0] pitch_ext;
  logic [31:0] dword_swapped;
  logic bpp8;

  // Applies the raster code bitwise; each index is {pattern, source, dest}.
  function automatic logic [7:0] apply_rop(input logic [7:0] code,
                                           input logic [7:0] p,
                                           input logic [7:0] s,
                                           input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = code[{p[i], s[i], d[i]}];
    end
    return r;
  endfunction

  // A term is used when the code differs across that operand's value.
  assign rop = setup_reg[bpt_pkg::SETUP_ROP_LSB +: 8];
  assign uses_pat = rop[7:4] != rop[3:0];
  assign uses_src = {rop[7:6], rop[3:2]} != {rop[5:4], rop[1:0]};
  assign uses_dst = {rop[7], rop[5], rop[3], rop[1]} !=
                    {rop[6], rop[4], rop[2], rop[0]};

  // Only 8 bpp is built; other depths raise a status flag but still run.
  assign bpp8 = setup_reg[bpt_pkg::SETUP_DYN_EN_BIT] &&
                setup_reg[bpt_pkg::SETUP_DYN_DEPTH_LSB +: 2] == 2'h0;

  // Pixel position, source bit and write qualification.
  assign is_text = op_reg == bpt_pkg::OP_TEXT_IMM;
  assign pix_bit = src_sel_reg & bits_reg[31];
  assign in_clip = x_reg >= clip_min_reg[15:0] &&
                   x_reg <= clip_max_reg[15:0] &&
                   y_reg >= clip_min_reg[31:16] &&
                   y_reg <= clip_max_reg[31:16];
  assign write_ok = !is_text ||
                    ((!clip_en_reg || in_clip) &&
                     (!trans_reg || pix_bit));
  assign last_x = x_reg == x_end_reg;
  assign last_y = y_reg == y_end_reg;

  // Colour expansion uses the low byte only at 8 bpp.
  assign src_byte = !is_text ? 8'h00 :
                    cur_bit_reg ? fg_reg[7:0] : bg_reg[7:0];
  assign result = apply_rop(rop, pat_byte_reg, src_byte,
                            dst_byte_reg);

  // Pattern tiling: row and column wrap modulo 8 from the rectangle origin.
  assign pat_row = 3'(y_reg - y_start_reg) +
                   setup_reg[bpt_pkg::SETUP_VALIGN_LSB +: 3];
  assign pat_col = 3'(x_reg - x_start_reg);
  assign pat_addr = {pat_base_reg[31:3], 3'h0} +
                    {26'h0, pat_row, pat_col};
  assign pix_addr = line_addr_reg + {16'h0, x_reg};

  // Helpers for line addressing.
  assign pitch_ext = {{16{pitch_reg[15]}}, pitch_reg};
  assign y1_offset = 33'($signed({1'b0, arg1_reg[31:16]}) *
                         $signed(pitch_reg));
  // Stream bytes go low byte first, each byte most significant bit first.
  assign dword_swapped = {i_cmd_data[7:0], i_cmd_data[15:8],
                          i_cmd_data[23:16], i_cmd_data[31:24]};

  // The streamer is served only while a dword is actually wanted.
  assign o_cmd_ready = state_reg == bpt_pkg::ST_IDLE ||
                       state_reg == bpt_pkg::ST_ARG1 ||
                       state_reg == bpt_pkg::ST_ARG2 ||
                       state_reg == bpt_pkg::ST_SRC;
  assign o_busy = state_reg != bpt_pkg::ST_IDLE;

  // Memory strobes are held while the state waits for the port.
  assign o_mem_rd = state_reg == bpt_pkg::ST_PRD ||
                    state_reg == bpt_pkg::ST_DRD;
  assign o_mem_wr = state_reg == bpt_pkg::ST_WR;
  assign o_mem_addr = state_reg == bpt_pkg::ST_PRD ? pat_addr : pix_addr;
  assign o_mem_wdata = result;

  // One wait state on every bus access keeps read data registered.
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  assign o_avs_readdata = rdata_reg;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
    end
  end

  // Register writes take effect on the edge where waitrequest is low.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      setup_reg <= bpt_pkg::SETUP_RESET;
      pitch_reg <= 16'h0000;
      pat_base_reg <= 32'h0000_0000;
      dst_base_reg <= 32'h0000_0000;
      fg_reg <= 32'h0000_0000;
      bg_reg <= 32'h0000_0000;
      clip_min_reg <= 32'h0000_0000;
      clip_max_reg <= 32'h0000_0000;
    end else if (i_avs_write && ack_reg) begin
      unique case (i_avs_address)
        bpt_pkg::OFS_SETUP: setup_reg <= i_avs_writedata;
        bpt_pkg::OFS_PITCH: pitch_reg <= i_avs_writedata[15:0];
        bpt_pkg::OFS_PAT_BASE: pat_base_reg <= i_avs_writedata;
        bpt_pkg::OFS_DST_BASE: dst_base_reg <= i_avs_writedata;
        bpt_pkg::OFS_FG: fg_reg <= i_avs_writedata;
        bpt_pkg::OFS_BG: bg_reg <= i_avs_writedata;
        bpt_pkg::OFS_CLIP_MIN: clip_min_reg <= i_avs_writedata;
        bpt_pkg::OFS_CLIP_MAX: clip_max_reg <= i_avs_writedata;
        default: begin
        end
      endcase
    end
  end

  // Read data is sampled in the wait cycle and held through the answer.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (i_avs_read && !ack_reg) begin
      unique case (i_avs_address)
        bpt_pkg::OFS_STATUS: rdata_reg <= {29'h0, !bpp8, 1'b0, o_busy};
        bpt_pkg::OFS_SETUP: rdata_reg <= setup_reg;
        bpt_pkg::OFS_PITCH: rdata_reg <= {16'h0, pitch_reg};
        bpt_pkg::OFS_PAT_BASE: rdata_reg <= pat_base_reg;
        bpt_pkg::OFS_DST_BASE: rdata_reg <= dst_base_reg;
        bpt_pkg::OFS_FG: rdata_reg <= fg_reg;
        bpt_pkg::OFS_BG: rdata_reg <= bg_reg;
        bpt_pkg::OFS_CLIP_MIN: rdata_reg <= clip_min_reg;
        bpt_pkg::OFS_CLIP_MAX: rdata_reg <= clip_max_reg;
        bpt_pkg::OFS_DONE_CNT: rdata_reg <= {16'h0, done_cnt_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Command sequencer; a new command is taken only from idle.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= bpt_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        bpt_pkg::ST_IDLE: begin
          if (i_cmd_valid) begin
            if (i_cmd_data[bpt_pkg::CMD_OP_LSB +: 2] ==
                    bpt_pkg::OP_PATTERN_FILL ||
                i_cmd_data[bpt_pkg::CMD_OP_LSB +: 2] ==
                    bpt_pkg::OP_TEXT_IMM) begin
              state_reg <= bpt_pkg::ST_ARG1;
            end
          end
        end
        bpt_pkg::ST_ARG1: begin
          if (i_cmd_valid) begin
            state_reg <= bpt_pkg::ST_ARG2;
          end
        end
        bpt_pkg::ST_ARG2: begin
          if (i_cmd_valid) begin
            if (!is_text && (arg1_reg[31:16] == 16'h0 ||
                             arg1_reg[15:0] == 16'h0)) begin
              state_reg <= bpt_pkg::ST_IDLE;
            end else if (is_text && (i_cmd_data[31:16] < arg1_reg[31:16] ||
                                     i_cmd_data[15:0] < arg1_reg[15:0])) begin
              state_reg <= bpt_pkg::ST_IDLE;
            end else begin
              state_reg <= bpt_pkg::ST_PIX;
            end
          end
        end
        bpt_pkg::ST_PIX: begin
          if (is_text && src_sel_reg && bit_cnt_reg == 6'h0) begin
            state_reg <= bpt_pkg::ST_SRC;
          end else if (!write_ok) begin
            if (last_x && last_y) begin
              state_reg <= bpt_pkg::ST_IDLE;
            end
          end else if (uses_pat) begin
            state_reg <= bpt_pkg::ST_PRD;
          end else if (uses_dst) begin
            state_reg <= bpt_pkg::ST_DRD;
          end else begin
            state_reg <= bpt_pkg::ST_WR;
          end
        end
        bpt_pkg::ST_SRC: begin
          if (i_cmd_valid) begin
            state_reg <= bpt_pkg::ST_PIX;
          end
        end
        bpt_pkg::ST_PRD: begin
          if (!i_mem_wait) begin
            state_reg <= uses_dst ? bpt_pkg::ST_DRD : bpt_pkg::ST_WR;
          end
        end
        bpt_pkg::ST_DRD: begin
          if (!i_mem_wait) begin
            state_reg <= bpt_pkg::ST_WR;
          end
        end
        bpt_pkg::ST_WR: begin
          if (!i_mem_wait) begin
            state_reg <= (last_x && last_y) ?
                         bpt_pkg::ST_IDLE : bpt_pkg::ST_PIX;
          end
        end
      endcase
    end
  end

  // Latches the command header; only the source select is dropped when the command is not text.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_reg <= 2'h0;
      src_sel_reg <= 1'b0;
      clip_en_reg <= 1'b0;
      trans_reg <= 1'b0;
      arg1_reg <= 32'h0000_0000;
    end else if (state_reg == bpt_pkg::ST_IDLE && i_cmd_valid) begin
      op_reg <= i_cmd_data[bpt_pkg::CMD_OP_LSB +: 2];
      // The source select has no meaning for a fill and is forced off.
      src_sel_reg <= i_cmd_data[bpt_pkg::CMD_SRC_SEL_BIT] &&
                     i_cmd_data[1:0] == bpt_pkg::OP_TEXT_IMM;
      clip_en_reg <= i_cmd_data[bpt_pkg::CMD_CLIP_EN_BIT];
      trans_reg <= i_cmd_data[bpt_pkg::CMD_TRANS_BIT];
    end else if (state_reg == bpt_pkg::ST_ARG1 && i_cmd_valid) begin
      arg1_reg <= i_cmd_data;
    end
  end

  // Rectangle set-up and the pixel walk.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      line_addr_reg <= 32'h0000_0000;
      x_reg <= 16'h0000;
      y_reg <= 16'h0000;
      x_start_reg <= 16'h0000;
      x_end_reg <= 16'h0000;
      y_start_reg <= 16'h0000;
      y_end_reg <= 16'h0000;
    end else if (state_reg == bpt_pkg::ST_ARG2 && i_cmd_valid) begin
      if (is_text) begin
        // Extent from the corner coordinates; width and height unused.
        x_start_reg <= arg1_reg[15:0];
        y_start_reg <= arg1_reg[31:16];
        x_end_reg <= i_cmd_data[15:0];
        y_end_reg <= i_cmd_data[31:16];
        x_reg <= arg1_reg[15:0];
        y_reg <= arg1_reg[31:16];
        line_addr_reg <= dst_base_reg + y1_offset[31:0];
      end else begin
        // Height in scan lines, width in bytes, start at the given byte.
        x_start_reg <= 16'h0000;
        y_start_reg <= 16'h0000;
        x_end_reg <= arg1_reg[15:0] - 16'h0001;
        y_end_reg <= arg1_reg[31:16] - 16'h0001;
        x_reg <= 16'h0000;
        y_reg <= 16'h0000;
        line_addr_reg <= i_cmd_data;
      end
    end else if ((state_reg == bpt_pkg::ST_WR && !i_mem_wait) ||
                 (state_reg == bpt_pkg::ST_PIX && !write_ok &&
                  !(is_text && src_sel_reg && bit_cnt_reg == 6'h0))) begin
      if (last_x) begin
        x_reg <= x_start_reg;
        y_reg <= y_reg + 16'h0001;
        line_addr_reg <= line_addr_reg + pitch_ext;
      end else begin
        x_reg <= x_reg + 16'h0001;
      end
    end
  end

  // Glyph bit stream runs on across scan lines without realignment.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bits_reg <= 32'h0000_0000;
      bit_cnt_reg <= 6'h00;
      cur_bit_reg <= 1'b0;
    end else if (state_reg == bpt_pkg::ST_IDLE) begin
      // Leftover bits of a previous glyph belong to no command.
      bit_cnt_reg <= 6'h00;
    end else if (state_reg == bpt_pkg::ST_SRC && i_cmd_valid) begin
      bits_reg <= dword_swapped;
      bit_cnt_reg <= 6'h20;
    end else if (state_reg == bpt_pkg::ST_PIX && is_text &&
                 !(src_sel_reg && bit_cnt_reg == 6'h0)) begin
      cur_bit_reg <= pix_bit;
      bits_reg <= {bits_reg[30:0], 1'b0};
      if (src_sel_reg) begin
        bit_cnt_reg <= bit_cnt_reg - 6'h01;
      end
    end
  end

  // Operand bytes; an unread operand is zero so it cannot leak.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pat_byte_reg <= 8'h00;
      dst_byte_reg <= 8'h00;
    end else if (state_reg == bpt_pkg::ST_PIX) begin
      pat_byte_reg <= 8'h00;
      dst_byte_reg <= 8'h00;
    end else if (state_reg == bpt_pkg::ST_PRD && !i_mem_wait) begin
      pat_byte_reg <= i_mem_rdata;
    end else if (state_reg == bpt_pkg::ST_DRD && !i_mem_wait) begin
      dst_byte_reg <= i_mem_rdata;
    end
  end

  // Completed commands, counted when the last pixel is settled.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      done_cnt_reg <= 16'h0000;
    end else if (state_reg != bpt_pkg::ST_IDLE && last_x && last_y &&
                 ((state_reg == bpt_pkg::ST_WR && !i_mem_wait) ||
                  (state_reg == bpt_pkg::ST_PIX && !write_ok &&
                   !(is_text && src_sel_reg &&
                     bit_cnt_reg == 6'h0)))) begin
      done_cnt_reg <= done_cnt_reg + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// ### bench/bpt_engine_monitor.sv
// Port checker for the pattern fill and text draw engine.
`timescale 1ns/1ps
`default_nettype none
module bpt_engine_monitor (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_cmd_valid,
  input wire logic [31:0] i_cmd_data,
  input wire logic o_cmd_ready,
  input wire logic o_mem_rd,
  input wire logic o_mem_wr,
  input wire logic [31:0] o_mem_addr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic i_mem_wait,
  input wire logic o_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  // One wait state per register access, then the word is taken.
  wait_one_a: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest) else $error("wait state");
  rdata_hold_a: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data moved");
  mem_excl_a: assert property (!(o_mem_rd && o_mem_wr))
    else $error("read and write together");
  // A stalled access must not drift while memory is busy.
  wr_hold_a: assert property (o_mem_wr && i_mem_wait |=> o_mem_wr &&
    $stable(o_mem_addr) && $stable(o_mem_wdata)) else $error("write moved");
  rd_hold_a: assert property (o_mem_rd && i_mem_wait |=> o_mem_rd &&
    $stable(o_mem_addr)) else $error("read moved");
  idle_quiet_a: assert property (!o_busy |-> !o_mem_rd && !o_mem_wr)
    else $error("memory access while idle");
  draw_no_cmd_a: assert property ((o_mem_rd || o_mem_wr) |->
    !o_cmd_ready) else $error("command taken while drawing");
  fill_start_a: assert property (i_cmd_valid && o_cmd_ready && !o_busy &&
    i_cmd_data[1:0] == 2'h1 |=> o_busy) else $error("fill not started");
  bad_op_a: assert property (i_cmd_valid && o_cmd_ready && !o_busy &&
    i_cmd_data[1:0] == 2'h0 |=> !o_busy) else $error("bad opcode ran");
endmodule

bind bpt_engine bpt_engine_monitor u_mon (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_cmd_valid(i_cmd_valid), .i_cmd_data(i_cmd_data),
  .o_cmd_ready(o_cmd_ready), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
  .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
  .i_mem_wait(i_mem_wait), .o_busy(o_busy));
`default_nettype wire

// ### bench/bpt_cmd_stream.sv
// Command streamer model handing ring-buffer dwords to the engine.
`timescale 1ns/1ps
`default_nettype none
module bpt_cmd_stream (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ready,
  output logic o_valid,
  output logic [31:0] o_data
);
  logic [31:0] ring_q[$];

  // Host software appends packets; glyph bytes follow their command.
  task automatic push(input logic [31:0] d);
    ring_q.push_back(d);
  endtask

  initial begin
    o_valid = 1'b0;
    o_data = 32'h0;
  end

  // Dwords leave strictly in order and stay offered until taken.
  // Idle data toggles so a stale word is never mistaken for a new one.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_valid <= 1'b0;
    end else begin
      if (o_valid && i_ready) begin
        void'(ring_q.pop_front());
      end
      if (o_valid && !i_ready) begin
        o_valid <= 1'b1;
      end else if (ring_q.size() > 0 && $urandom_range(3) != 0) begin
        o_valid <= 1'b1;
        o_data <= ring_q[0];
      end else begin
        o_valid <= 1'b0;
        o_data <= ~o_data;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/bpt_engine_test.sv
// Self-checking bench for the pattern fill and text draw engine.
`timescale 1ns/1ps
`default_nettype none
module bpt_engine_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_addr = 6'h00;
  logic avs_rd = 1'b0;
  logic avs_wr = 1'b0;
  logic [31:0] avs_wdata = 32'h0;
  logic [31:0] avs_rdata, cmd_data, mem_addr, rv;
  logic avs_wait, cmd_valid, cmd_ready, mem_rd, mem_wr, busy;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata = 8'h00;
  logic mem_wait = 1'b0;
  logic [7:0] mem [int];
  logic [31:0] got_a[$];
  logic [7:0] got_d[$];
  int exp_a[$];
  int exp_d[$];
  int rd_cnt = 0;
  int error_cnt = 0;
  int num_checks = 0;
  int pitch = 64;
  int fg = 32'hABCD_EF00;
  int bg = 32'h77;

  always #2 clk = ~clk;

  bpt_engine DUT (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_avs_address(avs_addr), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
    .i_avs_writedata(avs_wdata), .o_avs_readdata(avs_rdata),
    .o_avs_waitrequest(avs_wait), .i_cmd_valid(cmd_valid),
    .i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready), .o_mem_rd(mem_rd),
    .o_mem_wr(mem_wr), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
    .i_mem_rdata(mem_rdata), .i_mem_wait(mem_wait), .o_busy(busy));

  bpt_cmd_stream u_stream (.i_clk(clk), .i_reset_n(rst_n),
    .i_ready(cmd_ready), .o_valid(cmd_valid), .o_data(cmd_data));

  function automatic logic [7:0] mem_byte(input int a);
    return mem.exists(a) ? mem[a] : 8'hA5;
  endfunction

  // Frame memory: a new access always waits a cycle, so read data is ready.
  always @(posedge clk) begin
    if (mem_rd && !mem_wait) begin
      rd_cnt++;
    end
    if (mem_wr && !mem_wait) begin
      got_a.push_back(mem_addr);
      got_d.push_back(mem_wdata);
      mem[int'(mem_addr)] = mem_wdata;
    end
    mem_rdata <= mem_byte(int'(mem_addr));
    mem_wait <= ($urandom_range(2) == 0) ||
                !((mem_rd || mem_wr) && mem_wait);
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_val(input string name, input logic [31:0] e,
                         input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  // Writes are compared in order, so pixel order is checked as well.
  task automatic chk_writes(input string name);
    num_checks++;
    if (got_a.size() != exp_a.size()) begin
      error_cnt++;
      $display("mismatch %s count expected %0d seen %0d", name,
               exp_a.size(), got_a.size());
    end
    foreach (exp_a[i]) begin
      if (i < got_a.size() && (got_a[i] !== 32'(exp_a[i]) ||
          got_d[i] !== 8'(exp_d[i]))) begin
        error_cnt++;
        $display("mismatch %s expected %h:%h seen %h:%h", name, exp_a[i],
                 exp_d[i], got_a[i], got_d[i]);
      end
    end
    exp_a.delete();
    exp_d.delete();
    got_a.delete();
    got_d.delete();
  endtask

  // Avalon master: hold the request until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_addr <= a;
    avs_wdata <= d;
    avs_rd <= !wr;
    avs_wr <= wr;
    @(posedge clk);
    while (avs_wait === 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    q = avs_rdata;
    if (n >= 20) begin
      error_cnt++;
      report_and_stop();
    end
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while ((u_stream.ring_q.size() != 0 || busy !== 1'b0) && n < 5000) begin
      n++;
      @(posedge clk);
    end
    if (n >= 5000) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic do_fill(input int rop, input int va, input int w,
                         input int h, input int dst);
    int r0;
    bus(1'b1, bpt_pkg::OFS_SETUP, 32'(rop | (va << 8) | 32'h800), rv);
    r0 = rd_cnt;
    for (int y = 0; y < h; y++) begin
      for (int x = 0; x < w; x++) begin
        exp_a.push_back(dst + y * pitch + x);
        exp_d.push_back(rop == 8'hF0 ? mem_byte(32'h1000 +
          ((y + va) % 8) * 8 + x % 8) : 0);
      end
    end
    u_stream.push(32'h1);
    u_stream.push({16'(h), 16'(w)});
    u_stream.push(32'(dst));
    wait_done();
    chk_writes("fill");
    chk_val("fill reads", rop == 8'hF0 ? w * h : 0, rd_cnt - r0);
  endtask

  task automatic do_text(input int ctl, input int x1, input int y1,
                         input int x2, input int y2);
    logic [7:0] gly[$];
    int k, b, r0, nb;
    bus(1'b1, bpt_pkg::OFS_SETUP, 32'h8CC, rv);
    k = 0;
    r0 = rd_cnt;
    nb = ((x2 - x1 + 1) * (y2 - y1 + 1) + 31) / 32 * 4;
    for (int i = 0; i < nb; i++) begin
      gly.push_back(8'($urandom));
    end
    for (int y = y1; y <= y2; y++) begin
      for (int x = x1; x <= x2; x++) begin
        b = gly[k / 8][7 - k % 8];
        k++;
        if ((!ctl[3] || (x >= 22 && x <= 40 && y <= 9)) &&
            (!ctl[4] || b == 1)) begin
          exp_a.push_back(32'h2000 + y * pitch + x);
          exp_d.push_back(b == 1 ? fg & 8'hFF : bg & 8'hFF);
        end
      end
    end
    u_stream.push(32'(ctl));
    u_stream.push({16'(y1), 16'(x1)});
    u_stream.push({16'(y2), 16'(x2)});
    for (int i = 0; i < nb; i += 4) begin
      u_stream.push({gly[i + 3], gly[i + 2], gly[i + 1], gly[i]});
    end
    wait_done();
    chk_writes("text");
    chk_val("text reads", 0, rd_cnt - r0);
  endtask

  // Main sequence: reset, register checks, fills, then text draws.
  initial begin
    void'($urandom(32'h90d7));
    for (int i = 0; i < 64; i++) begin
      mem[32'h1000 + i] = 8'(i * 7 + 3);
    end
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, bpt_pkg::OFS_SETUP, 32'h0, rv);
    chk_val("setup reset", bpt_pkg::SETUP_RESET, rv);
    bus(1'b0, bpt_pkg::OFS_STATUS, 32'h0, rv);
    chk_val("status reset", 32'h4, rv);
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF, rv);
    bus(1'b0, 6'h3C, 32'h0, rv);
    chk_val("unmapped", 32'h0, rv);
    bus(1'b1, bpt_pkg::OFS_PITCH, 32'(pitch), rv);
    bus(1'b1, bpt_pkg::OFS_PAT_BASE, 32'h1005, rv);
    bus(1'b1, bpt_pkg::OFS_DST_BASE, 32'h2000, rv);
    bus(1'b1, bpt_pkg::OFS_FG, 32'(fg), rv);
    bus(1'b1, bpt_pkg::OFS_BG, 32'(bg), rv);
    bus(1'b1, bpt_pkg::OFS_CLIP_MIN, 32'h0000_0016, rv);
    bus(1'b1, bpt_pkg::OFS_CLIP_MAX, 32'h0009_0028, rv);
    do_fill(8'hF0, 0, 10, 9, 32'h3000);
    bus(1'b0, bpt_pkg::OFS_STATUS, 32'h0, rv);
    chk_val("status", 32'h0, rv);
    do_fill(8'hF0, 5, 3, 10, 32'h3400);
    do_fill(8'hCC, 0, 3, 2, 32'h3800);
    u_stream.push(32'h0);
    do_fill(8'hF0, 0, 1, 1, 32'h3A00);
    do_text(32'h1E, 20, 4, 27, 11);
    do_text(32'h06, 3, 1, 7, 3);
    bus(1'b0, bpt_pkg::OFS_DONE_CNT, 32'h0, rv);
    chk_val("done count", 32'h6, rv);
    report_and_stop();
  end
endmodule
`default_nettype wire
